// ---- sarc_top.sv ----
// Conversion control and serial output of a 16-bit SAR converter.
// Assumes the start input and chain mode pin come from outside, and the
// serial clock is its own domain driven by the host.
`timescale 1ns/10ps
module sarc_top #(
    parameter int POR_CYCLES = sarc_pkg::POR_INIT_CYC,
    parameter int CONV_CYCLES = sarc_pkg::CONV_CYC
) (
    // Core clock and power-on reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Conversion control
    input wire logic convert_start_i,
    input wire logic [sarc_pkg::DATA_W-1:0] sample_i,
    output logic busy_o,
    output logic ready_o,
    output logic power_down_o,
    // Serial link
    input wire logic sck_i,
    input wire logic read_enable_or_chain_in_i,
    input wire logic daisy_mode_select_i,
    output logic sdo_o,
    output logic sdo_oe_o
);
    import sarc_pkg::*;

    // ************************************
    // Input synchronisers, core side
    // ************************************
    // Two stages on the start, mode and sample pins; the read enable pin is used without stages
    logic [1:0] cnv_sync;
    logic [1:0] next_cnv_sync;

    logic cnv_prev;
    logic next_cnv_prev;

    logic [1:0] mode_sync;
    logic [1:0] next_mode_sync;

    logic [DATA_W-1:0] samp_s1;
    logic [DATA_W-1:0] next_samp_s1;
    logic [DATA_W-1:0] samp_s2;
    logic [DATA_W-1:0] next_samp_s2;

    always_comb begin
        next_cnv_sync = {cnv_sync[0], convert_start_i};
        next_cnv_prev = cnv_sync[1];
        next_mode_sync = {mode_sync[0], daisy_mode_select_i};
        // The sample only matters at conversion end, long after it settles
        next_samp_s1 = sample_i;
        next_samp_s2 = samp_s1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Idle high, so a pin already high at release is no edge
            cnv_sync <= 2'h3;
            cnv_prev <= 1'b1;
            mode_sync <= 2'h0;
            samp_s1 <= RESULT_RST;
            samp_s2 <= RESULT_RST;
        end else begin
            cnv_sync <= next_cnv_sync;
            cnv_prev <= next_cnv_prev;
            mode_sync <= next_mode_sync;
            samp_s1 <= next_samp_s1;
            samp_s2 <= next_samp_s2;
        end
    end

    // ************************************
    // Reinitialisation after power-on
    // ************************************
    logic [15:0] por_cnt;
    logic [15:0] next_por_cnt;

    logic rdy;
    logic next_rdy;

    // Starts are refused until the count runs out
    // Ready never falls again short of another reset
    always_comb begin
        next_por_cnt = por_cnt;
        next_rdy = rdy;
        if (por_cnt != 16'(POR_CYCLES)) begin
            next_por_cnt = por_cnt + 16'h0001;
        end else begin
            next_rdy = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            por_cnt <= 16'h0000;
            rdy <= 1'b0;
        end else begin
            por_cnt <= next_por_cnt;
            rdy <= next_rdy;
        end
    end

    // ************************************
    // Conversion timer
    // ************************************
    // Stands in for the internal oscillator: a fixed count of core clocks
    sarc_state_t state;
    sarc_state_t next_state;

    logic [15:0] conv_cnt;
    logic [15:0] next_conv_cnt;
    logic conv_last;

    assign conv_last = (conv_cnt == 16'(CONV_CYCLES - 1));

    always_comb begin
        next_conv_cnt = conv_cnt;
        if (state == SARC_CONV && !conv_last) begin
            next_conv_cnt = conv_cnt + 16'h0001;
        end else begin
            // Cleared while idle so each conversion counts from zero
            next_conv_cnt = 16'h0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_cnt <= 16'h0000;
        end else begin
            conv_cnt <= next_conv_cnt;
        end
    end

    // ************************************
    // Conversion sequencer
    // ************************************
    logic busy;
    logic next_busy;

    logic pdn;
    logic next_pdn;

    logic cnv_rise;

    assign cnv_rise = cnv_sync[1] & ~cnv_prev;

    // Limitation: a start that rises while busy is lost, not queued
    always_comb begin
        next_state = state;
        next_busy = busy;
        next_pdn = pdn;
        unique case (state)
            SARC_ACQ: begin
                if (cnv_rise && rdy) begin
                    next_state = SARC_CONV;
                    next_busy = 1'b1;
                end
            end
            SARC_PDN: begin
                // A low start pin wakes the core; its next rise is a start
                if (!cnv_sync[1]) begin
                    next_state = SARC_ACQ;
                    next_pdn = 1'b0;
                end
            end
            SARC_CONV: begin
                // Start rises in here are ignored; the pin level at the last count picks power-down
                if (conv_last) begin
                    next_busy = 1'b0;
                    if (cnv_sync[1]) begin
                        next_state = SARC_PDN;
                        next_pdn = 1'b1;
                    end else begin
                        next_state = SARC_ACQ;
                    end
                end
            end
            default: begin
                next_state = SARC_ACQ;
                next_busy = 1'b0;
                next_pdn = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= SARC_ACQ;
            busy <= 1'b0;
            pdn <= 1'b0;
        end else begin
            state <= next_state;
            busy <= next_busy;
            pdn <= next_pdn;
        end
    end

    // ************************************
    // Result register
    // ************************************
    logic [DATA_W-1:0] result;
    logic [DATA_W-1:0] next_result;

    always_comb begin
        next_result = result;
        // Taken once, at the close of a conversion; held through power-down
        if (state == SARC_CONV && conv_last) begin
            next_result = samp_s2;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result <= RESULT_RST;
        end else begin
            result <= next_result;
        end
    end

    // ************************************
    // Result hand-over to the link side
    // ************************************
    // A new result stays pending until the link side reports its first
    // shift; that report comes back as a toggle through two stages.
    // The toggle changes at most once per frame, so one bit crosses.
    logic fresh;
    logic next_fresh;

    logic [2:0] ack_sync;
    logic [2:0] next_ack_sync;
    logic ack_seen;

    logic ack_tgl;

    assign ack_seen = ack_sync[2] ^ ack_sync[1];

    always_comb begin
        next_ack_sync = {ack_sync[1:0], ack_tgl};
        next_fresh = fresh;
        if (ack_seen) begin
            next_fresh = 1'b0;
        end
        // A finishing conversion beats a late acknowledge
        if (state == SARC_CONV && conv_last) begin
            next_fresh = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fresh <= 1'b0;
            ack_sync <= 3'h0;
        end else begin
            fresh <= next_fresh;
            ack_sync <= next_ack_sync;
        end
    end

    // ************************************
    // Serial output, link clock domain
    // ************************************
    // The serial clock stands still around reset and between frames, so
    // these flops clear asynchronously. The pending flag and the result
    // are read here without stages: both settle long before the first
    // link edge that the host may give after busy falls.
    logic [DATA_W-1:0] shreg;
    logic [DATA_W-1:0] next_shreg;

    logic [DATA_W-1:0] shift_src;
    logic next_ack_tgl;
    logic take;

    // Pending and not yet taken in this frame
    assign take = fresh & ~(ack_tgl ^ ack_sync[2]);

    // One stage per bit: the first edge of a frame loads from the result
    // one place up, later edges shift; bit 0 always takes the pin, which
    // is low while reading in normal mode and upstream data in chain mode.
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++) begin : g_stage
            if (gi == 0) begin : g_low
                assign shift_src[gi] = read_enable_or_chain_in_i;
            end else begin : g_up
                assign shift_src[gi] = take ? result[gi-1]
                    : shreg[gi-1];
            end
        end
    endgenerate

    always_comb begin
        next_shreg = shift_src;
        next_ack_tgl = ack_tgl ^ take;
    end

    always_ff @(posedge sck_i or posedge rst_i) begin
        if (rst_i) begin
            shreg <= RESULT_RST;
            ack_tgl <= 1'b0;
        end else begin
            shreg <= next_shreg;
            ack_tgl <= next_ack_tgl;
        end
    end

    // ************************************
    // Outputs
    // ************************************
    // Enable and data follow the pin and the pending flag without a
    // register: the top bit must stand before any link edge arrives.
    assign sdo_oe_o = mode_sync[1]
        | ~read_enable_or_chain_in_i;
    assign sdo_o = take ? result[DATA_W-1]
        : shreg[DATA_W-1];

    assign busy_o = busy;
    assign ready_o = rdy;
    assign power_down_o = pdn;

endmodule // sarc_top

// ---- sarc_pkg.sv ----
// Package for the converter control and serial readout block.
// Assumes a 40 MHz core clock; timing counts derive from it.
package sarc_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int DATA_W = 16;
    // Conversion time, longest allowed
    localparam int CONV_MAX_NS = 730;
    localparam int CONV_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
    // Reinitialisation after power-on reset
    localparam int POR_INIT_US = 20;
    localparam int POR_INIT_CYC = (POR_INIT_US * 1000) / CLK_PERIOD_NS;
    // Reset value of the result register
    localparam logic [15:0] RESULT_RST = 16'h0000;
    typedef enum logic [1:0] {
        SARC_ACQ = 2'b00,
        SARC_CONV = 2'b01,
        SARC_PDN = 2'b10
    } sarc_state_t;
endpackage

// ---- dummy_end.sv ----
`timescale 1ns/10ps

// ---- sarc_sva.sv ----
// Checker for the converter control block.
// Assumes it is bound to sarc_top.
`timescale 1ns/10ps
module sarc_sva #(parameter int CONV_CYCLES = 29) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic convert_start_i,
    input wire logic busy_o,
    input wire logic ready_o,
    input wire logic power_down_o,
    input wire logic read_enable_or_chain_in_i,
    input wire logic daisy_mode_select_i,
    input wire logic sdo_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence start_s;
        $rose(convert_start_i) && ready_o && !busy_o;
    endsequence
    a_reset_state: assert property ($fell(rst_i) |->
        !busy_o && !ready_o && !power_down_o) else $error("reset state");
    a_ready_wait: assert property ($fell(rst_i) |-> !ready_o [*8])
        else $error("ready early");
    a_start_busy: assert property (start_s |-> ##[1:4] busy_o)
        else $error("start missed");
    a_conv_bound: assert property ($rose(busy_o) |->
        ##[1:CONV_CYCLES] $fell(busy_o)) else $error("conversion long");
    a_busy_solid: assert property ($rose(busy_o) |-> busy_o [*8])
        else $error("busy short");
    a_pdn_entry: assert property ($fell(busy_o) && convert_start_i
        |-> ##[0:3] power_down_o) else $error("no power down");
    a_pdn_hold: assert property (power_down_o && convert_start_i
        |=> power_down_o) else $error("power down lost");
    a_oe_normal: assert property (!daisy_mode_select_i &&
        !$past(daisy_mode_select_i, 3) &&
        $stable(read_enable_or_chain_in_i) |->
        sdo_oe_o == !read_enable_or_chain_in_i) else $error("enable");
    a_oe_chain: assert property (daisy_mode_select_i &&
        $past(daisy_mode_select_i, 3) |-> sdo_oe_o)
        else $error("chain not driven");
endmodule // sarc_sva
bind sarc_top sarc_sva #(.CONV_CYCLES(CONV_CYCLES)) u_sva (.clk_i,
    .rst_i, .convert_start_i, .busy_o, .ready_o, .power_down_o,
    .read_enable_or_chain_in_i, .daisy_mode_select_i, .sdo_oe_o);

// ---- sarc_host.sv ----
// Host model: start, serial clock and read enable.
// Assumes its tasks are called at a falling core clock edge.
`timescale 1ns/10ps
module sarc_host (
    input wire logic clk_i,
    input wire logic sdo_i,
    output logic cs_o = 1'b1,
    output logic sck_o = 1'b0,
    output logic re_o = 1'b1
);
    task automatic start();
        cs_o = 1'b0;
        repeat (8) @(negedge clk_i);
        cs_o = 1'b1;
    endtask
    // Slow clock; full throughput is not the aim here
    task automatic shift(int n, logic [15:0] up, output logic [31:0] q);
        q = '0;
        // Serial clock is already low here, ahead of the enable
        re_o = up[15];
        for (int i = 0; i < n; i++) begin
            #16 q = {q[30:0], sdo_i};
            sck_o = 1'b1;
            #16 sck_o = 1'b0;
            re_o = i < 15 ? up[14-i] : 1'b0;
        end
        #16 re_o = 1'b1;
    endtask
endmodule // sarc_host

// ---- sarc_top_tb.sv ----
// Bench for the converter control block with its host model.
// Assumes the hand-over timing of busy and the serial load.
`timescale 1ns/10ps
module sarc_top_tb;
    import sarc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [DATA_W-1:0] sample_i = 16'h0000;
    logic daisy_mode_select_i = 1'b0;
    logic cs, sck, re, busy_o, ready_o, power_down_o, sdo_o, sdo_oe_o;
    int err_total = 0;
    int n_tests = 0;
    int w;
    logic [31:0] q;
    initial forever #12.5 clk_i = ~clk_i;
    sarc_host host (.clk_i, .sdo_i(sdo_o), .cs_o(cs), .sck_o(sck), .re_o(re));
    sarc_top #(.POR_CYCLES(40)) DUT (.clk_i, .rst_i, .convert_start_i(cs),
        .sample_i, .busy_o, .ready_o, .power_down_o, .sck_i(sck),
        .read_enable_or_chain_in_i(re), .daisy_mode_select_i, .sdo_o,
        .sdo_oe_o);
    task automatic chk(string nm, logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic test_done();
        if (err_total == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Bounded wait for busy (s=0) or ready (s=1)
    task automatic await(int s, logic v);
        for (w = 0; w < 64 && (s ? ready_o : busy_o) !== v; w++)
            @(negedge clk_i);
        if (w == 64) begin
            chk("timeout", 0, 1);
            test_done();
        end
    endtask
    task automatic t_por();
        chk("ready", 0, ready_o);
        host.start();
        repeat (4) @(negedge clk_i);
        chk("early", 0, busy_o);
        await(1, 1);
    endtask
    task automatic t_norm();
        sample_i = 16'ha5c3;
        host.start();
        await(0, 1);
        await(0, 0);
        chk("conv", 1, w <= CONV_CYC);
        repeat (3) @(negedge clk_i);
        chk("pdn", 1, power_down_o);
        host.shift(16, 16'h0000, q);
        @(negedge clk_i);
        chk("data", 32'ha5c3, q);
        chk("oe", 0, sdo_oe_o);
    endtask
    task automatic t_ign();
        host.start();
        await(0, 1);
        host.start();
        await(0, 0);
        repeat (8) @(negedge clk_i);
        chk("restart", 0, busy_o);
    endtask
    task automatic t_chain();
        daisy_mode_select_i = 1'b1;
        sample_i = 16'h3c96;
        host.start();
        await(0, 1);
        await(0, 0);
        host.shift(32, 16'h8e71, q);
        @(negedge clk_i);
        chk("chain", 32'h3c968e71, q);
        chk("oe_chain", 1, sdo_oe_o);
    endtask
    initial begin
        repeat (6) @(negedge clk_i);
        rst_i = 1'b0;
        t_por();
        t_norm();
        t_ign();
        t_chain();
        test_done();
    end
endmodule // sarc_top_tb
